// *** rtl/fp_lane_addsub.sv ***
// one binary floating-point lane adder/subtractor with selectable rounding
`timescale 1ns/1ps
`include "simd_unit_defs.svh"
module fp_lane_addsub
	import simd_unit_pkg::*;
#(
	parameter int EXP = `SP_EXP,
	parameter int MAN = `SP_MAN
) (
	input  wire logic [EXP+MAN:0] x,
	input  wire logic [EXP+MAN:0] y,
	input  wire logic             subtract,
	input  wire round_e           rmode,
	output logic      [EXP+MAN:0] sum
);
	localparam int W    = MAN + 4;
	localparam int EMAX = (1 << EXP) - 1;

	logic             sx, sy, sb, ss, nan_x, nan_y, inf_x, inf_y;
	logic             swap, eff_sub, sign, inc, ovf_inf;
	logic [EXP-1:0]   ex, ey;
	logic [W-1:0]     fb, fs, sm, m;
	logic [2*W-1:0]   wide;
	logic [W:0]       r;
	logic [MAN+1:0]   rk;
	int               eb, es, d, e, ef;

	// force the quiet bit of a signalling NaN
	function automatic logic [EXP+MAN:0] quiet(input logic [EXP+MAN:0] v);
		quiet = v | {{(EXP+1){1'b0}}, 1'b1, {(MAN-1){1'b0}}};
	endfunction : quiet

	always_comb begin
		sx    = x[EXP+MAN];
		sy    = y[EXP+MAN] ^ subtract;
		ex    = x[EXP+MAN-1:MAN];
		ey    = y[EXP+MAN-1:MAN];
		nan_x = (&ex) && (|x[MAN-1:0]);
		nan_y = (&ey) && (|y[MAN-1:0]);
		inf_x = (&ex) && !(|x[MAN-1:0]);
		inf_y = (&ey) && !(|y[MAN-1:0]);
		// larger magnitude first so the difference never goes negative
		swap  = y[EXP+MAN-1:0] > x[EXP+MAN-1:0];
		sb    = swap ? sy : sx;
		ss    = swap ? sx : sy;
		eb    = swap ? int'(ey) : int'(ex);
		es    = swap ? int'(ex) : int'(ey);
		fb    = swap ? {|ey, y[MAN-1:0], 3'h0} : {|ex, x[MAN-1:0], 3'h0};
		fs    = swap ? {|ex, x[MAN-1:0], 3'h0} : {|ey, y[MAN-1:0], 3'h0};
		// denormals share the exponent of the smallest normal
		if (eb == 0) eb = 1;
		if (es == 0) es = 1;
		d = eb - es;
		if (d > W) d = W;
		wide    = {fs, {W{1'b0}}} >> d;
		sm      = wide[2*W-1:W] | {{(W-1){1'b0}}, |wide[W-1:0]};
		eff_sub = sb ^ ss;
		r       = eff_sub ? {1'b0, fb} - {1'b0, sm} : {1'b0, fb} + {1'b0, sm};
		sign    = sb;
		e       = eb;
		if (r[W]) begin
			m = {r[W:2], r[1] | r[0]};
			e = eb + 1;
		end else begin
			m = r[W-1:0];
		end
		// normalise, but stop at the denormal exponent
		for (int i = 0; i < W; i++) begin
			if (!m[W-1] && e > 1) begin
				m = m << 1;
				e = e - 1;
			end
		end
		// exact cancellation is +0 except when rounding toward minus infinity
		if (m == '0 && eff_sub) sign = (rmode == RM_DOWN);
		inc = 1'b0;
		unique case (rmode)
			RM_NEAREST: inc = m[2] & (m[3] | (|m[1:0]));
			RM_DOWN:    inc = sign & (|m[2:0]);
			RM_UP:      inc = !sign & (|m[2:0]);
			RM_ZERO:    inc = 1'b0;
		endcase
		rk = {1'b0, m[W-1:3]} + {{(MAN+1){1'b0}}, inc};
		if (rk[MAN+1]) begin
			ef = e + 1;
			rk = rk >> 1;
		end else begin
			ef = rk[MAN] ? e : 0;
		end
		ovf_inf = (rmode == RM_NEAREST) || (rmode == RM_UP && !sign)
			|| (rmode == RM_DOWN && sign);
		if (ef >= EMAX) begin
			sum = ovf_inf ? {sign, {EXP{1'b1}}, {MAN{1'b0}}}
				: {sign, {(EXP-1){1'b1}}, 1'b0, {MAN{1'b1}}};
		end else begin
			sum = {sign, EXP'(ef), rk[MAN-1:0]};
		end
		// specials override the datapath
		if (nan_x) begin
			sum = quiet(x);
		end else if (nan_y) begin
			sum = quiet(y);
		end else if (inf_x && inf_y && (sx != sy)) begin
			sum = {1'b1, {EXP{1'b1}}, 1'b1, {(MAN-1){1'b0}}};
		end else if (inf_x) begin
			sum = x;
		end else if (inf_y) begin
			sum = {sy, y[EXP+MAN-1:0]};
		end
	end
endmodule : fp_lane_addsub

// *** rtl/simd_addsub_horizontal_dup_unit.sv ***
// packed alternating, horizontal, duplicate, truncating store and unaligned load unit
//
// Behaviour
// - single alternating op subtracts element pairs one and three, adds two and four.
// - double alternating op subtracts low quadword pair, adds high quadword pair.
// - single horizontal add gives A1+A2, A3+A4, B1+B2, B3+B4.
// - single horizontal sub gives A1-A2, A3-A4, B1-B2, B3-B4.
// - double horizontal add: low is sum of A, high is sum of B.
// - double horizontal sub: low is A1-A2, high is B1-B2.
// - odd duplicate copies element two to one/two, element four to three/four.
// - even duplicate copies element one to one/two, element three to three/four.
// - quadword duplicate puts source bits 63:0 in both result halves.
// - truncating store equals rounding store but always rounds toward zero.
// - unaligned load returns 128 bits at any byte offset, merged across two aligned lines.
`timescale 1ns/1ps
`include "simd_unit_defs.svh"
module simd_addsub_horizontal_dup_unit
	import simd_unit_pkg::*;
(
	input  wire logic    MCLK,
	input  wire logic    RESET,
	input  wire logic    CLK_EN,
	input  wire issue_s  ISSUE,
	output result_s      RESULT
);
	unit_state_s st;
	unit_state_s next_st;
	vec_t        sp_sum;
	vec_t        dp_sum;
	logic        is_alt_ps;
	logic        is_alt_pd;

	// double to signed 64-bit integer, indefinite on overflow or NaN
	function automatic logic [63:0] to_int(input logic [63:0] v, input round_e rm);
		logic [127:0] w;
		logic [64:0]  mag;
		logic [64:0]  lim;
		logic         tiny, st_bit, rnd, neg;
		int           u;
		neg    = v[63];
		u      = int'(v[62:52]) - `DP_BIAS;
		tiny   = u < -12;
		w      = tiny ? '0 : {75'h0, (v[62:52] != 11'h0), v[51:0]} << (u + 12);
		st_bit = tiny ? (v[62:0] != 63'h0) : (|w[62:0]);
		rnd    = 1'b0;
		unique case (rm)
			RM_NEAREST: rnd = w[63] & (st_bit | w[64]);
			RM_DOWN:    rnd = neg & (w[63] | st_bit);
			RM_UP:      rnd = !neg & (w[63] | st_bit);
			RM_ZERO:    rnd = 1'b0;
		endcase
		mag = {1'b0, w[127:64]} + {64'h0, rnd};
		lim = {2'h0, {63{1'b1}}} + {64'h0, neg};
		if ((&v[62:52]) || u > 63 || mag > lim) begin
			to_int = `INT_INDEFINITE;
		end else begin
			to_int = neg ? 64'(-mag) : mag[63:0];
		end
	endfunction : to_int

	// pick 16 bytes out of two aligned lines starting at a byte offset
	function automatic vec_t funnel(input vec_t lo, input vec_t hi,
		input logic [`OFFSET_W-1:0] off);
		logic [2*`VEC_W-1:0] both;
		both   = {hi, lo} >> (off * `BYTE_W);
		funnel = both[`VEC_W-1:0];
	endfunction : funnel

	assign is_alt_ps = ISSUE.op == OP_ALT_PS;
	assign is_alt_pd = ISSUE.op == OP_ALT_PD;

	// four single lanes; operands chosen per op
	for (genvar i = 0; i < 4; i++) begin : g_sp
		logic [`LANE_SP-1:0] x;
		logic [`LANE_SP-1:0] y;
		logic                sub;
		vec_t                src;
		assign src = (i < 2) ? ISSUE.a : ISSUE.b;
		assign x   = is_alt_ps ? ISSUE.a[32*i +: 32] : src[64*(i%2) +: 32];
		assign y   = is_alt_ps ? ISSUE.b[32*i +: 32] : src[64*(i%2)+32 +: 32];
		assign sub = is_alt_ps ? (i % 2 == 0) : (ISSUE.op == OP_HSUB_PS);
		fp_lane_addsub #(.EXP(`SP_EXP), .MAN(`SP_MAN)) u_lane (
			.x        (x),
			.y        (y),
			.subtract (sub),
			.rmode    (ISSUE.vec_round),
			.sum      (sp_sum[32*i +: 32])
		);
	end

	// two double lanes
	for (genvar j = 0; j < 2; j++) begin : g_dp
		logic [`LANE_DP-1:0] x;
		logic [`LANE_DP-1:0] y;
		logic                sub;
		vec_t                src;
		assign src = (j == 0) ? ISSUE.a : ISSUE.b;
		assign x   = is_alt_pd ? ISSUE.a[64*j +: 64] : src[63:0];
		assign y   = is_alt_pd ? ISSUE.b[64*j +: 64] : src[127:64];
		assign sub = is_alt_pd ? (j == 0) : (ISSUE.op == OP_HSUB_PD);
		fp_lane_addsub #(.EXP(`DP_EXP), .MAN(`DP_MAN)) u_lane (
			.x        (x),
			.y        (y),
			.subtract (sub),
			.rmode    (ISSUE.vec_round),
			.sum      (dp_sum[64*j +: 64])
		);
	end

	// result select; data holds when nothing issues
	always_comb begin
		next_st             = st;
		next_st.res.valid   = ISSUE.valid;
		next_st.res.pop     = 1'b0;
		next_st.res.illegal = 1'b0;
		if (ISSUE.valid) begin
			unique case (ISSUE.op)
				OP_ALT_PS, OP_HADD_PS, OP_HSUB_PS: begin
					next_st.res.data = sp_sum;
				end
				OP_ALT_PD, OP_HADD_PD, OP_HSUB_PD: begin
					next_st.res.data = dp_sum;
				end
				OP_ODD_DUP: begin
					next_st.res.data = {{2{ISSUE.a[127:96]}}, {2{ISSUE.a[63:32]}}};
				end
				OP_EVEN_DUP: begin
					next_st.res.data = {{2{ISSUE.a[95:64]}}, {2{ISSUE.a[31:0]}}};
				end
				OP_QUAD_DUP: begin
					next_st.res.data = {2{ISSUE.a[63:0]}};
				end
				OP_TRUNC_STORE: begin
					next_st.res.data = {64'h0, to_int(ISSUE.a[63:0], RM_ZERO)};
					next_st.res.pop  = 1'b1;
				end
				OP_ROUND_STORE: begin
					next_st.res.data = {64'h0, to_int(ISSUE.a[63:0], ISSUE.x87_round)};
					next_st.res.pop  = 1'b1;
				end
				OP_ULOAD: begin
					next_st.res.data = funnel(ISSUE.a, ISSUE.b, ISSUE.offset);
				end
				default: begin
					next_st.res.data    = '0;
					next_st.res.illegal = 1'b1;
				end
			endcase
		end
	end

	// single state register; clock enable freezes everything
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			st <= '0;
		end else if (CLK_EN) begin
			st <= next_st;
		end
	end

	assign RESULT = st.res;

	// x equals y, finite
	function automatic logic same32(input logic [31:0] p, input logic [31:0] q);
		same32 = (p == q) && !(&q[30:23]);
	endfunction : same32

	// x is minus y, finite
	function automatic logic neg32(input logic [31:0] p, input logic [31:0] q);
		neg32 = (p == {~q[31], q[30:0]}) && !(&q[30:23]);
	endfunction : neg32

	function automatic logic same64(input logic [63:0] p, input logic [63:0] q);
		same64 = (p == q) && !(&q[62:52]);
	endfunction : same64

	function automatic logic neg64(input logic [63:0] p, input logic [63:0] q);
		neg64 = (p == {~q[63], q[62:0]}) && !(&q[62:52]);
	endfunction : neg64

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	sequence took(simd_op_e o);
		CLK_EN && ISSUE.valid && ISSUE.op == o;
	endsequence

	alt_ps_sub_a: assert property (took(OP_ALT_PS) ##0 same32(ISSUE.a[31:0], ISSUE.b[31:0])
		|=> RESULT.data[30:0] == 31'h0) else $error("alternating lane one did not subtract");
	alt_ps_add_a: assert property (took(OP_ALT_PS) ##0 neg32(ISSUE.a[63:32], ISSUE.b[63:32])
		|=> RESULT.data[62:32] == 31'h0) else $error("alternating lane two did not add");
	alt_pd_pair_a: assert property (took(OP_ALT_PD) ##0 (same64(ISSUE.a[63:0], ISSUE.b[63:0])
		&& neg64(ISSUE.a[127:64], ISSUE.b[127:64]))
		|=> RESULT.data[62:0] == 63'h0 && RESULT.data[126:64] == 63'h0)
		else $error("double alternating op wrong");
	hadd_ps_pair_a: assert property (took(OP_HADD_PS) ##0 neg32(ISSUE.a[63:32], ISSUE.a[31:0])
		|=> RESULT.data[30:0] == 31'h0) else $error("horizontal add lane one wrong");
	hsub_ps_pair_a: assert property (took(OP_HSUB_PS)
		##0 same32(ISSUE.b[127:96], ISSUE.b[95:64])
		|=> RESULT.data[126:96] == 31'h0) else $error("horizontal sub lane four wrong");
	hadd_pd_high_a: assert property (took(OP_HADD_PD)
		##0 neg64(ISSUE.b[127:64], ISSUE.b[63:0])
		|=> RESULT.data[126:64] == 63'h0) else $error("double horizontal add high wrong");
	hsub_pd_low_a: assert property (took(OP_HSUB_PD)
		##0 same64(ISSUE.a[127:64], ISSUE.a[63:0])
		|=> RESULT.data[62:0] == 63'h0) else $error("double horizontal sub low wrong");
	odd_dup_a: assert property (took(OP_ODD_DUP) |=> RESULT.data ==
		{{2{$past(ISSUE.a[127:96])}}, {2{$past(ISSUE.a[63:32])}}}) else $error("odd dup wrong");
	even_dup_a: assert property (took(OP_EVEN_DUP) |=> RESULT.data ==
		{{2{$past(ISSUE.a[95:64])}}, {2{$past(ISSUE.a[31:0])}}}) else $error("even dup wrong");
	quad_dup_a: assert property (took(OP_QUAD_DUP) |=>
		RESULT.data == {2{$past(ISSUE.a[63:0])}}) else $error("quadword dup wrong");
	// fractions chop to zero in any mode
	trunc_small_a: assert property (took(OP_TRUNC_STORE) ##0 (ISSUE.a[62:52] < `DP_BIAS)
		|=> RESULT.data == '0 && RESULT.pop) else $error("truncating store rounded");
	uload_a: assert property (took(OP_ULOAD) |=> RESULT.data ==
		funnel($past(ISSUE.a), $past(ISSUE.b), $past(ISSUE.offset))) else $error("load merge wrong");
	nan_lane_a: assert property (took(OP_ALT_PS)
		##0 ((&ISSUE.a[30:23]) && (|ISSUE.a[22:0]))
		|=> (&RESULT.data[30:22])) else $error("NaN not propagated quiet");
	valid_follow_a: assert property (CLK_EN |=> RESULT.valid == $past(ISSUE.valid))
		else $error("result valid not one cycle after issue");
endmodule : simd_addsub_horizontal_dup_unit

// *** rtl/simd_unit_defs.svh ***
// widths, field positions and fixed values shared by the packed arithmetic unit
`ifndef SIMD_UNIT_DEFS_SVH
`define SIMD_UNIT_DEFS_SVH
`define VEC_W          128
`define LANE_SP        32
`define LANE_DP        64
`define SP_EXP         8
`define SP_MAN         23
`define DP_EXP         11
`define DP_MAN         52
`define DP_BIAS        1023
`define BYTE_W         8
`define OFFSET_W       4
`define INT_INDEFINITE 64'h8000_0000_0000_0000
`endif

// *** rtl/simd_unit_pkg.sv ***
// types shared by the packed arithmetic unit and its lane adders
`include "simd_unit_defs.svh"
package simd_unit_pkg;
	typedef logic [`VEC_W-1:0] vec_t;

	typedef enum logic [3:0] {
		OP_ALT_PS      = 4'h0,
		OP_ALT_PD      = 4'h1,
		OP_HADD_PS     = 4'h2,
		OP_HSUB_PS     = 4'h3,
		OP_HADD_PD     = 4'h4,
		OP_HSUB_PD     = 4'h5,
		OP_ODD_DUP     = 4'h6,
		OP_EVEN_DUP    = 4'h7,
		OP_QUAD_DUP    = 4'h8,
		OP_TRUNC_STORE = 4'h9,
		OP_ROUND_STORE = 4'hA,
		OP_ULOAD       = 4'hB
	} simd_op_e;

	typedef enum logic [1:0] {
		RM_NEAREST = 2'b00,
		RM_DOWN    = 2'b01,
		RM_UP      = 2'b10,
		RM_ZERO    = 2'b11
	} round_e;

	typedef struct packed {
		logic                  valid;
		simd_op_e              op;
		vec_t                  a;
		vec_t                  b;
		logic [`OFFSET_W-1:0]  offset;
		round_e                vec_round;
		round_e                x87_round;
	} issue_s;

	typedef struct packed {
		logic valid;
		logic pop;
		logic illegal;
		vec_t data;
	} result_s;

	typedef struct packed {
		result_s res;
	} unit_state_s;
endpackage : simd_unit_pkg

// *** sim/issue_model.sv ***
// issue-side model: presents requests to the unit and scrambles fields between them
`timescale 1ns/1ps
module issue_model
	import simd_unit_pkg::*;
(
	input  wire logic MCLK,
	input  wire logic CLK_EN,
	output issue_s    ISSUE
);
	initial begin
		ISSUE = '0;
	end

	// present at the falling edge, hold until an enabled rising edge takes it
	task automatic send(input issue_s req, output bit taken);
		int n;
		@(negedge MCLK);
		ISSUE = req;
		taken = 1'b0;
		for (n = 0; n < 20 && !taken; n++) begin
			@(posedge MCLK);
			taken = CLK_EN;
		end
	endtask : send

	// released operands show their inverse so a unit that samples late sees junk
	task automatic idle();
		issue_s r;
		@(negedge MCLK);
		r = ISSUE;
		r.valid = 1'b0;
		r.a = ~r.a;
		r.b = ~r.b;
		r.offset = ~r.offset;
		ISSUE = r;
	endtask : idle
endmodule : issue_model

// *** sim/tb.sv ***
// self-checking bench for the packed alternating, horizontal and duplicate unit
`timescale 1ns/1ps
module tb;
	import simd_unit_pkg::*;
	logic          MCLK = 1'b0;
	logic          RESET = 1'b1;
	logic          CLK_EN = 1'b1;
	issue_s        ISSUE;
	result_s       RESULT;
	int            num_errors = 0;
	int            cmp_count = 0;
	int            seed = 32'h2ea306cb;
	logic [130:0]  notes[$];
	logic [130:0]  mon_exp;
	bit            en_prev = 1'b0;
	result_s       held = '0;

	always #12.5 MCLK = ~MCLK;

	simd_addsub_horizontal_dup_unit uut (.MCLK(MCLK), .RESET(RESET), .CLK_EN(CLK_EN),
		.ISSUE(ISSUE), .RESULT(RESULT));
	issue_model issuer (.MCLK(MCLK), .CLK_EN(CLK_EN), .ISSUE(ISSUE));

	task automatic chk(input string what, input logic [130:0] exp, input logic [130:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// results only count after an enabled edge; a frozen unit must not move at all
	always @(posedge MCLK) en_prev <= CLK_EN && !RESET;
	always @(negedge MCLK) begin
		if (RESET) begin
			chk("reset result", '0, RESULT);
		end else if (!en_prev) begin
			chk("frozen result", held, RESULT);
		end else if (RESULT.valid !== 1'b0) begin
			mon_exp = (notes.size() > 0) ? notes.pop_front() : '0;
			chk("result", mon_exp, RESULT);
		end else begin
			chk("idle result", {3'h0, held.data}, RESULT);
		end
		held = RESULT;
	end

	// note the expectation first, then hand the request to the issue model
	task automatic issue(input simd_op_e op, input vec_t a, input vec_t b, input logic [3:0] off,
		input round_e vr, input round_e xr, input logic [130:0] exp);
		bit taken;
		notes.push_back(exp);
		issuer.send('{1'b1, op, a, b, off, vr, xr}, taken);
		if (!taken) begin
			num_errors++;
			$display("MISMATCH request accepted expected 1 seen 0");
			print_verdict();
		end
		if (($random(seed) & 3) == 0) begin
			issuer.idle();
		end
	endtask : issue

	task automatic end_test(input string name);
		int n;
		issuer.idle();
		for (n = 0; n < 50 && notes.size() > 0; n++) begin
			@(negedge MCLK);
		end
		if (notes.size() > 0) begin
			num_errors++;
			$display("MISMATCH pending results expected 0 seen %0d", notes.size());
			print_verdict();
		end
		$display("test %s done", name);
	endtask : end_test

	function automatic logic [31:0] spf(input int v);
		return $shortrealtobits(shortreal'(v));
	endfunction : spf

	function automatic logic [63:0] dpf(input int v);
		return $realtobits(real'(v));
	endfunction : dpf

	function automatic vec_t pack(input int v[4], input bit dp);
		return dp ? {dpf(v[1]), dpf(v[0])} : {spf(v[3]), spf(v[2]), spf(v[1]), spf(v[0])};
	endfunction : pack

	function automatic vec_t rnd();
		return {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction : rnd

	// small integers keep every lane exact, so rounding cannot blur the lane mapping
	task automatic arith(input simd_op_e op, input bit tie = 1'b0);
		int x[4];
		int y[4];
		int r[4];
		bit dp;
		dp = op inside {OP_ALT_PD, OP_HADD_PD, OP_HSUB_PD};
		foreach (x[i]) begin
			x[i] = $random(seed) % 1000;
			y[i] = $random(seed) % 1000;
		end
		// tied operands cancel one lane (two for the alternating ops) so the zero-result checks in the unit really fire
		if (tie) begin
			case (op)
				OP_ALT_PS, OP_ALT_PD: begin
					y[0] = x[0];
					y[1] = -x[1];
				end
				OP_HADD_PS: x[1] = -x[0];
				OP_HSUB_PS: y[3] = y[2];
				OP_HADD_PD: y[1] = -y[0];
				default: x[1] = x[0];
			endcase
		end
		case (op)
			OP_ALT_PS: r = '{x[0] - y[0], x[1] + y[1], x[2] - y[2], x[3] + y[3]};
			OP_ALT_PD: r = '{x[0] - y[0], x[1] + y[1], 0, 0};
			OP_HADD_PS: r = '{x[0] + x[1], x[2] + x[3], y[0] + y[1], y[2] + y[3]};
			OP_HSUB_PS: r = '{x[0] - x[1], x[2] - x[3], y[0] - y[1], y[2] - y[3]};
			OP_HADD_PD: r = '{x[0] + x[1], y[0] + y[1], 0, 0};
			default: r = '{x[0] - x[1], y[0] - y[1], 0, 0};
		endcase
		issue(op, pack(x, dp), pack(y, dp), 4'h0, RM_NEAREST, RM_NEAREST, {3'h4, pack(r, dp)});
	endtask : arith

	initial begin
		int o;
		int m;
		int s;
		longint k;
		longint e;
		vec_t a;
		vec_t b;
		logic [31:0] up_lane[4];
		up_lane = '{32'h3F800000, 32'h3F800000, 32'h3F800001, 32'h3F800000};
		repeat (12) @(negedge MCLK);
		RESET <= 1'b0;
		for (o = 0; o < 48; o++) begin
			arith(simd_op_e'(o % 6), o >= 24);
		end
		end_test("lane arithmetic");
		// 1 plus half an ulp: a tie that only rounding up moves off 1.0
		for (m = 0; m < 4; m++) begin
			issue(OP_ALT_PS, {4{32'h3F800000}}, {4{32'h33800000}}, 4'h0, round_e'(m), RM_NEAREST,
				{3'h4, up_lane[m], 32'h3F7FFFFF, up_lane[m], 32'h3F7FFFFF});
		end
		// a signalling NaN in lane one must come back quiet, other lanes unaffected
		issue(OP_ALT_PS, {{3{32'h3F800000}}, 32'h7FA00000}, {4{32'h33800000}}, 4'h0,
			RM_NEAREST, RM_NEAREST,
			{3'h4, 32'h3F800000, 32'h3F7FFFFF, 32'h3F800000, 32'h7FE00000});
		end_test("rounding modes");
		for (o = 0; o < 8; o++) begin
			a = rnd();
			b = rnd();
			issue(OP_ODD_DUP, a, b, 4'h0, RM_NEAREST, RM_NEAREST,
				{3'h4, {2{a[127:96]}}, {2{a[63:32]}}});
			issue(OP_EVEN_DUP, a, b, 4'h0, RM_NEAREST, RM_NEAREST,
				{3'h4, {2{a[95:64]}}, {2{a[31:0]}}});
			issue(OP_QUAD_DUP, a, b, 4'h0, RM_NEAREST, RM_NEAREST, {3'h4, {2{a[63:0]}}});
		end
		end_test("duplicate moves");
		// three-quarter values separate truncation from nearest and from rounding away from zero
		for (m = 0; m < 8; m++) begin
			k = 1 + ($random(seed) & 1023);
			s = (m < 4) ? 1 : -1;
			case (m % 4)
				0: e = s * (k + 1);
				1: e = (s > 0) ? k : -(k + 1);
				2: e = (s > 0) ? k + 1 : -k;
				default: e = s * k;
			endcase
			a = {64'h0, $realtobits(s * (k + 0.75))};
			issue(OP_TRUNC_STORE, a, rnd(), 4'h0, RM_NEAREST, round_e'(m % 4),
				{3'h6, 64'h0, s * k});
			issue(OP_ROUND_STORE, a, rnd(), 4'h0, RM_NEAREST, round_e'(m % 4),
				{3'h6, 64'h0, e});
		end
		issue(OP_TRUNC_STORE, {64'h0, $realtobits(1.0e30)}, '0, 4'h0, RM_NEAREST, RM_UP,
			{3'h6, 64'h0, 64'h8000000000000000});
		// a fraction below one chops to zero whatever the control word says
		issue(OP_TRUNC_STORE, {64'h0, $realtobits(-0.75)}, '0, 4'h0, RM_NEAREST, RM_UP,
			{3'h6, 128'h0});
		end_test("integer stores");
		for (o = 0; o < 16; o++) begin
			a = rnd();
			b = rnd();
			issue(OP_ULOAD, a, b, o[3:0], RM_NEAREST, RM_NEAREST,
				{3'h4, 128'({b, a} >> (8 * o))});
		end
		for (o = 12; o < 16; o++) begin
			issue(simd_op_e'(o), rnd(), rnd(), 4'h0, RM_NEAREST, RM_NEAREST, {3'h5, 128'h0});
		end
		end_test("unaligned load and unknown codes");
		// a request held across a frozen stretch must be taken once, when the enable returns
		a = rnd();
		issue(OP_ODD_DUP, a, '0, 4'h0, RM_NEAREST, RM_NEAREST,
			{3'h4, {2{a[127:96]}}, {2{a[63:32]}}});
		fork
			issue(OP_EVEN_DUP, a, '0, 4'h0, RM_NEAREST, RM_NEAREST,
				{3'h4, {2{a[95:64]}}, {2{a[31:0]}}});
			begin
				@(negedge MCLK);
				CLK_EN <= 1'b0;
				repeat (3) @(negedge MCLK);
				CLK_EN <= 1'b1;
			end
		join
		end_test("clock enable freeze");
		@(negedge MCLK);
		RESET <= 1'b1;
		repeat (2) @(negedge MCLK);
		RESET <= 1'b0;
		arith(OP_HADD_PS);
		end_test("second reset");
		print_verdict();
	end
endmodule : tb
